// ==== rss_exec.sv ====
// Decode and execute unit for rotate-right, fill-ones and halt instructions
//
// Function
// - Decode 010000 as rotate, d, a, f fields
// - Rotate right, bit 0 goes to bit 7
// - Rotate updates only negative and zero flags
// - d=0 writes accumulator, d=1 writes register
// - a=0 access bank, a=1 bank select
// - Decode 0110100 as fill, no flags touched
// - Fill writes FFh to register in phase 4
// - Halt clears powerdown, sets timeout flag
// - Halt clears watchdog, then sleeps
// - Watchdog wake clears the timeout flag
`timescale 1ns/10ps
module rss_exec
  import rss_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] instrWord,
  input  wire logic        instrValid,
  input  wire logic [3:0]  bankSelectValue,
  input  wire logic [7:0]  fileRdData,
  input  wire logic        wakeEvent,
  input  wire logic        wakeByWatchdog,
  output logic [11:0]      fileRdAddr,
  output logic             fileRdEn,
  output rss_fwr_type      fileWr,
  output logic [7:0]       accumulator,
  output rss_flag_type     flagUpd,
  output logic             timeoutFlag,
  output logic             powerdownFlag,
  output logic             watchdogClear,
  output logic             sleepMode,
  output logic             oscStop,
  output logic             instrDone
);

  // ****************************************
  // Helper functions
  // ****************************************
  // Bank resolution, used for read and write address
  function automatic logic [11:0] resolveAddr(input logic bankMode,
                                              input logic [3:0] bank_select_value,
                                              input logic [7:0] f);
    logic [3:0] bank;
    bank = bankMode ? bank_select_value : ACCESS_BANK;
    resolveAddr = {bank, f};
  endfunction

  function automatic logic [7:0] rotRight(input logic [7:0] v);
    rotRight = {v[0], v[7:1]};
  endfunction

  // ****************************************
  // Phase generator
  // ****************************************
  // Driven by the phase generator instance below the state declarations
  logic [3:0] phase;

  // ****************************************
  // State
  // ****************************************
  rss_op_type   op_reg,        op_next;
  logic         dest_reg,      dest_next;
  logic [11:0]  addr_reg,      addr_next;
  logic [7:0]   operand_reg,   operand_next;
  logic [7:0]   result_reg,    result_next;
  logic [11:0]  fileRdAddr_reg, fileRdAddr_next;
  logic         fileRdEn_reg,  fileRdEn_next;
  rss_fwr_type  fileWr_reg,    fileWr_next;
  logic [7:0]   acc_reg,       acc_next;
  rss_flag_type flagUpd_reg,   flagUpd_next;
  logic         timeout_reg,   timeout_next;
  logic         powerdown_reg, powerdown_next;
  logic         wdClear_reg,   wdClear_next;
  logic         sleepMode_reg, sleepMode_next;
  logic         done_reg,      done_next;
  logic [2:0]   wakeSync_reg;
  logic [2:0]   wakeSync_next;
  logic [2:0]   wdSync_reg;
  logic [2:0]   wdSync_next;
  logic         wakeSeen;
  logic         wdSeen;

  // Phases freeze while asleep, so wake always restarts at decode
  rss_phase_gen u_phase (
    .clk     (clk),
    .sys_rst (sys_rst),
    .run     (!sleepMode_reg),
    .phase   (phase)
  );

  // ****************************************
  // Wake input synchronisers
  // ****************************************
  // Wake sources are asynchronous pins; stages 2 and 3 must agree
  always_comb begin
    wakeSync_next = {wakeSync_reg[1:0], wakeEvent};
    wdSync_next   = {wdSync_reg[1:0], wakeByWatchdog};
    wakeSeen      = wakeSync_reg[1] & wakeSync_reg[2];
    wdSeen        = wdSync_reg[1] & wdSync_reg[2];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wakeSync_reg <= 3'h0;
      wdSync_reg   <= 3'h0;
    end else begin
      wakeSync_reg <= wakeSync_next;
      wdSync_reg   <= wdSync_next;
    end
  end

  // ****************************************
  // Decode and execute sequencing
  // ****************************************
  always_comb begin
    op_next         = op_reg;
    dest_next       = dest_reg;
    addr_next       = addr_reg;
    operand_next    = operand_reg;
    result_next     = result_reg;
    fileRdAddr_next = fileRdAddr_reg;
    fileRdEn_next   = 1'b0;
    fileWr_next     = '0;
    acc_next        = acc_reg;
    flagUpd_next    = '0;
    timeout_next    = timeout_reg;
    powerdown_next  = powerdown_reg;
    wdClear_next    = 1'b0;
    sleepMode_next  = sleepMode_reg;
    done_next       = 1'b0;

    if (sleepMode_reg) begin
      // Oscillator stopped; only a wake event restarts the core
      if (wakeSeen || wdSeen) begin
        sleepMode_next = 1'b0;
        if (wdSeen) begin
          timeout_next = 1'b0;
        end
      end
    end else if (phase[0]) begin
      // Phase 1: decode
      op_next   = OP_NONE;
      dest_next = 1'b0;
      addr_next = resolveAddr(instrWord[BANK_BIT], bankSelectValue, instrWord[7:0]);
      if (instrValid) begin
        if (instrWord[15:10] == ROT_OPC) begin
          op_next   = OP_ROT;
          dest_next = instrWord[DEST_BIT];
        end else if (instrWord[15:9] == FILL_OPC) begin
          op_next = OP_FILL;
        end else if (instrWord == HALT_CODE) begin
          op_next = OP_HALT;
        end
      end
    end else if (phase[1]) begin
      // Phase 2: register read request
      if (op_reg == OP_ROT || op_reg == OP_FILL) begin
        fileRdAddr_next = addr_reg;
        fileRdEn_next   = 1'b1;
      end
    end else if (phase[2]) begin
      // Phase 3: process; read data valid one cycle after request
      operand_next = fileRdData;
      case (op_reg)
        OP_ROT: begin
          result_next = rotRight(fileRdData);
        end
        OP_FILL: begin
          result_next = FILL_VALUE;
        end
        OP_HALT: begin
          powerdown_next = 1'b0;
          timeout_next   = 1'b1;
          wdClear_next   = 1'b1;
        end
        default: begin
          result_next = result_reg;
        end
      endcase
    end else begin
      // Phase 4: write to destination
      done_next = (op_reg != OP_NONE);
      case (op_reg)
        OP_ROT: begin
          if (dest_reg) begin
            fileWr_next = '{addr: addr_reg, data: result_reg, we: 1'b1};
          end else begin
            acc_next = result_reg;
          end
          flagUpd_next = '{negFlag: result_reg[7],
                           zeroFlag: (result_reg == 8'h00),
                           flagWe: 1'b1};
        end
        OP_FILL: begin
          fileWr_next = '{addr: addr_reg, data: result_reg, we: 1'b1};
        end
        OP_HALT: begin
          sleepMode_next = 1'b1;
        end
        default: begin
          done_next = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      op_reg         <= OP_NONE;
      dest_reg       <= 1'b0;
      addr_reg       <= 12'h000;
      operand_reg    <= 8'h00;
      result_reg     <= 8'h00;
      fileRdAddr_reg <= 12'h000;
      fileRdEn_reg   <= 1'b0;
      fileWr_reg     <= '0;
      acc_reg        <= ACC_RESET;
      flagUpd_reg    <= '0;
      timeout_reg    <= TO_RESET;
      powerdown_reg  <= PD_RESET;
      wdClear_reg    <= 1'b0;
      sleepMode_reg  <= 1'b0;
      done_reg       <= 1'b0;
    end else begin
      op_reg         <= op_next;
      dest_reg       <= dest_next;
      addr_reg       <= addr_next;
      operand_reg    <= operand_next;
      result_reg     <= result_next;
      fileRdAddr_reg <= fileRdAddr_next;
      fileRdEn_reg   <= fileRdEn_next;
      fileWr_reg     <= fileWr_next;
      acc_reg        <= acc_next;
      flagUpd_reg    <= flagUpd_next;
      timeout_reg    <= timeout_next;
      powerdown_reg  <= powerdown_next;
      wdClear_reg    <= wdClear_next;
      sleepMode_reg  <= sleepMode_next;
      done_reg       <= done_next;
    end
  end

  // ****************************************
  // Outputs, all registered
  // ****************************************
  assign fileRdAddr    = fileRdAddr_reg;
  assign fileRdEn      = fileRdEn_reg;
  assign fileWr        = fileWr_reg;
  assign accumulator   = acc_reg;
  assign flagUpd       = flagUpd_reg;
  assign timeoutFlag   = timeout_reg;
  assign powerdownFlag = powerdown_reg;
  assign watchdogClear = wdClear_reg;
  assign sleepMode     = sleepMode_reg;
  assign oscStop       = sleepMode_reg;  // Same flop: oscillator off while asleep
  assign instrDone     = done_reg;

endmodule

// ==== rss_pkg.sv ====
// Package with encodings, field positions and constants for the rotate/fill/halt executor
package rss_pkg;

  // ****************************************
  // Opcode matching
  // ****************************************
  localparam logic [5:0]  ROT_OPC      = 6'h10;   // Upper six bits 010000
  localparam logic [6:0]  FILL_OPC     = 7'h34;   // Upper seven bits 0110100
  localparam logic [15:0] HALT_CODE    = 16'h0003;
  localparam int          DEST_BIT     = 9;
  localparam int          BANK_BIT     = 8;
  localparam logic [7:0]  FILL_VALUE   = 8'hff;
  localparam logic [3:0]  ACCESS_BANK  = 4'h0;    // Fixed access bank number
  localparam logic [7:0]  ACC_RESET    = 8'h00;
  localparam logic        TO_RESET     = 1'b1;
  localparam logic        PD_RESET     = 1'b1;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    OP_NONE,
    OP_ROT,
    OP_FILL,
    OP_HALT
  } rss_op_type;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  data;
    logic        we;
  } rss_fwr_type;

  typedef struct packed {
    logic negFlag;
    logic zeroFlag;
    logic flagWe;
  } rss_flag_type;

endpackage

// ==== rss_phase_gen.sv ====
// Four-phase generator splitting the core clock into instruction phases
`timescale 1ns/10ps
module rss_phase_gen (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       run,
  output logic [3:0]      phase
);

  logic [3:0] phase_reg;
  logic [3:0] phase_next;

  // ****************************************
  // Rotating one-hot phase
  // ****************************************
  // Stopped clock holds phase 1 so wake resumes cleanly
  always_comb begin
    if (!run) begin
      phase_next = 4'h1;
    end else begin
      phase_next = {phase_reg[2:0], phase_reg[3]};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      phase_reg <= 4'h1;
    end else begin
      phase_reg <= phase_next;
    end
  end

  assign phase = phase_reg;

endmodule

// ==== rss_exec_sva.sv ====
// Port-level assertions for the rotate/fill/halt executor
`timescale 1ns/10ps
module rss_exec_sva
  import rss_pkg::*;
(
  input wire logic         clk,
  input wire logic         sys_rst,
  input wire logic [15:0]  instrWord,
  input wire logic [3:0]   bankSelectValue,
  input wire logic [7:0]   fileRdData,
  input wire logic         wakeByWatchdog,
  input wire logic [11:0]  fileRdAddr,
  input wire logic         fileRdEn,
  input wire rss_fwr_type  fileWr,
  input wire logic [7:0]   accumulator,
  input wire rss_flag_type flagUpd,
  input wire logic         timeoutFlag,
  input wire logic         powerdownFlag,
  input wire logic         watchdogClear,
  input wire logic         sleepMode,
  input wire logic         instrDone
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Read side: word and bank were taken two cycles before the strobe
  AST_RD_BANK: assert property (fileRdEn |-> fileRdAddr[11:8] ==
    ($past(instrWord[8], 2) ? $past(bankSelectValue, 2) : ACCESS_BANK)) else $error("bank");
  AST_READ_DONE: assert property (fileRdEn |-> ##2 instrDone)
    else $error("no done after read");
  // Results: source byte seen two cycles before the write
  AST_ROT_DATA: assert property (fileWr.we && flagUpd.flagWe |-> fileWr.data ==
    {$past(fileRdData[0], 2), $past(fileRdData[7:1], 2)}) else $error("rotate data");
  AST_ROT_FLAGS: assert property (flagUpd.flagWe |-> flagUpd.negFlag ==
    $past(fileRdData[0], 2) && flagUpd.zeroFlag == ($past(fileRdData, 2) == 8'h00))
    else $error("flags");
  AST_ACC_ROT: assert property (flagUpd.flagWe && !fileWr.we |-> accumulator ==
    {$past(fileRdData[0], 2), $past(fileRdData[7:1], 2)}) else $error("acc data");
  AST_ACC_HOLD: assert property (fileWr.we |-> $stable(accumulator))
    else $error("acc moved on write");
  AST_FILL_DATA: assert property (fileWr.we && !flagUpd.flagWe |->
    fileWr.data == FILL_VALUE) else $error("fill data");
  // Halt and wake side effects
  AST_HALT: assert property (watchdogClear |->
    timeoutFlag && !powerdownFlag ##1 sleepMode) else $error("halt flags");
  AST_WD_WAKE: assert property ($fell(sleepMode) && $past(wakeByWatchdog, 3) |->
    !timeoutFlag) else $error("timeout kept");
  CVR_ROT_WB: cover property (fileWr.we && flagUpd.flagWe);
  CVR_FILL: cover property (fileWr.we && !flagUpd.flagWe);
  CVR_WAKE: cover property ($fell(sleepMode));
endmodule

// ==== rss_file_model.sv ====
// Register file model facing the executor
`timescale 1ns/10ps
module rss_file_model
  import rss_pkg::*;
(
  input  wire logic        clk,
  input  wire logic [11:0] fileRdAddr,
  input  wire logic        fileRdEn,
  input  wire rss_fwr_type fileWr,
  output logic [7:0]       fileRdData
);
  logic [7:0] mem [4096];
  // Preload: each location holds its own low address byte
  initial for (int i = 0; i < 4096; i++) mem[i] = i[7:0];
  // Inverted data when not strobed, so a late sample shows up
  always_comb fileRdData = fileRdEn ? mem[fileRdAddr] : ~mem[fileRdAddr];
  always @(posedge clk) if (fileWr.we) mem[fileWr.addr] <= fileWr.data;
endmodule

// ==== test_rss_exec.sv ====
// Directed testbench for the rotate/fill/halt executor
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_total++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module test_rss_exec import rss_pkg::*;;
  logic         clk = 1'b0;
  logic         sys_rst = 1'b1;
  logic [15:0]  instrWord = 16'h0000;
  logic         instrValid = 1'b0;
  logic [3:0]   bankSelectValue = 4'h0;
  logic         wakeEvent = 1'b0;
  logic         wakeByWatchdog = 1'b0;
  logic [7:0]   fileRdData, accumulator;
  logic [11:0]  fileRdAddr, rdAddr;
  logic         fileRdEn, timeoutFlag, powerdownFlag, watchdogClear;
  logic         sleepMode, oscStop, instrDone;
  rss_fwr_type  fileWr, wrSeen;
  rss_flag_type flagUpd, flagSeen;
  int           err_total = 0, n_checks = 0, nWr = 0, nFlag = 0, nDone = 0, nWdc = 0;

  always #12.5 clk = ~clk;
  rss_exec dut (.clk, .sys_rst, .instrWord, .instrValid, .bankSelectValue, .fileRdData,
    .wakeEvent, .wakeByWatchdog, .fileRdAddr, .fileRdEn, .fileWr, .accumulator, .flagUpd,
    .timeoutFlag, .powerdownFlag, .watchdogClear, .sleepMode, .oscStop, .instrDone);
  rss_file_model peer (.clk, .fileRdAddr, .fileRdEn, .fileWr, .fileRdData);

  // Pulse counters; values sampled are those of the cycle just ended
  always @(posedge clk) begin
    if (fileWr.we) wrSeen = fileWr;
    if (flagUpd.flagWe) flagSeen = flagUpd;
    if (fileRdEn) rdAddr = fileRdAddr;
    nWr += fileWr.we;
    nFlag += flagUpd.flagWe;
    nDone += instrDone;
    nWdc += watchdogClear;
  end

  // One instruction slot is four clocks, held for the whole slot
  task automatic slot(input logic v, input logic [15:0] w, input logic [3:0] b);
    instrValid <= v;
    instrWord <= w;
    bankSelectValue <= b;
    repeat (4) @(posedge clk);
  endtask

  task automatic reset_dut();
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    `CHK("reset", 10'h003, {accumulator, timeoutFlag, powerdownFlag})
  endtask

  // Issue one word, let it complete in an idle slot, then compare
  task automatic run(input logic v, input logic [15:0] w, input logic [3:0] b,
    input logic [7:0] acc, input logic wr, input logic [11:0] ad, input logic [7:0] dat,
    input logic fl, input logic n, input logic z);
    int w0, f0, d0;
    w0 = nWr;
    f0 = nFlag;
    d0 = nDone;
    slot(v, w, b);
    slot(1'b0, 16'h0000, b);
    #1;
    `CHK("acc", acc, accumulator)
    `CHK("writes", wr, nWr - w0)
    `CHK("flagwr", fl, nFlag - f0)
    `CHK("done", wr | fl, nDone - d0)
    if (wr) `CHK("wr", {ad, dat}, {wrSeen.addr, wrSeen.data})
    if (fl) `CHK("nz", {n, z}, {flagSeen.negFlag, flagSeen.zeroFlag})
    if (wr | fl) `CHK("rdaddr", ad, rdAddr)
    $display("word %h finished", w);
  endtask

  // Halt, prove words are ignored asleep, then wake from either source
  task automatic doze(input logic wd, input logic [7:0] acc);
    int i, c0;
    c0 = nWdc;
    slot(1'b1, HALT_CODE, 4'h0);
    slot(1'b0, 16'h0000, 4'h0);
    #1;
    `CHK("wdclear", 1, nWdc - c0)
    `CHK("tf pd", 2'b10, {timeoutFlag, powerdownFlag})
    `CHK("sleep", 2'b11, {sleepMode, oscStop})
    run(1'b1, 16'h40d7, 4'h3, acc, 0, 12'h000, 8'h00, 0, 0, 0);
    if (wd) wakeByWatchdog <= 1'b1;
    else wakeEvent <= 1'b1;
    for (i = 0; i < 12 && sleepMode === 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (sleepMode !== 1'b0) begin
      err_total++;
      close_out();
    end
    `CHK("timeout", !wd, timeoutFlag)
    wakeByWatchdog <= 1'b0;
    wakeEvent <= 1'b0;
    $display("halt test finished");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    reset_dut();
    run(1'b1, 16'h435a, 4'h3, 8'h00, 1, 12'h35a, 8'h2d, 1, 0, 0);
    run(1'b1, 16'h40d7, 4'h3, 8'heb, 0, 12'h0d7, 8'h00, 1, 1, 0);
    run(1'b1, 16'h415a, 4'h3, 8'h96, 0, 12'h35a, 8'h00, 1, 1, 0);
    run(1'b1, 16'h4000, 4'h3, 8'h00, 0, 12'h000, 8'h00, 1, 0, 1);
    run(1'b1, 16'h6912, 4'h5, 8'h00, 1, 12'h512, 8'hff, 0, 0, 0);
    run(1'b1, 16'h6834, 4'h5, 8'h00, 1, 12'h034, 8'hff, 0, 0, 0);
    run(1'b1, 16'h4034, 4'h5, 8'hff, 0, 12'h034, 8'h00, 1, 1, 0);
    run(1'b1, 16'hf123, 4'h5, 8'hff, 0, 12'h000, 8'h00, 0, 0, 0);
    run(1'b0, 16'h4300, 4'h5, 8'hff, 0, 12'h000, 8'h00, 0, 0, 0);
    doze(1'b1, 8'hff);
    reset_dut();
    doze(1'b0, 8'h00);
    reset_dut();
    close_out();
  end

  // Hang guard well above the test run length
  initial begin
    #1000000;
    err_total++;
    close_out();
  end
endmodule

bind rss_exec rss_exec_sva chk (.clk, .sys_rst, .instrWord, .bankSelectValue, .fileRdData,
  .wakeByWatchdog, .fileRdAddr, .fileRdEn, .fileWr, .accumulator, .flagUpd, .timeoutFlag,
  .powerdownFlag, .watchdogClear, .sleepMode, .instrDone);
